/* File: rtl/gio_unit.sv */
// Guarded integer operations and high-word cycle counter read
// Functional notes
// - High cycle read returns slave counter bits 63:32, slot 3, one cycle latency.
// - Slave counter loads master only on successful interruptible jump and reset.
// - Low and high reads without jump between form one coherent snapshot.
// - Count-stall bit set: master counts every cycle; clear: only non-stall cycles.
// - Destination written only when guard lsb is one.
// - Absolute value: signed operand, unsigned magnitude, one cycle, slots 1 to 5.
// - Absolute value runs as two-operand form with zero first operand.
// - Add writes wrapped 32-bit sum, no overflow flag, one cycle.
// - Add-immediate adds unsigned 7-bit modifier, one cycle.
// - Average: sign-extend, add plus one, shift right one, two cycles.
`timescale 1ns/1ps
module gio_unit
    import gio_pkg::*;
(
    input  wire logic                  CLK,          // Core clock, 10 MHz
    input  wire logic                  SYS_RST,      // Async processor reset, high
    input  wire gio_pkg::gio_issue_t   ISSUE,        // Issued operation
    input  wire logic                  STALL,        // Processor stalled this cycle
    input  wire logic                  COUNT_STALL,  // Count-stall bit of status word
    input  wire logic                  IJMP_DONE,    // Interruptible jump completed
    output gio_pkg::gio_wb_t           ALU_WB,       // One-cycle result writeback
    output gio_pkg::gio_wb_t           AVG_WB,       // Two-cycle average writeback
    output logic [GIO_DW-1:0]          SNAP_LO       // Slave counter low word, for the low read
);
    import gio_pkg::*;

    // --------------------------------------------------------------
    // Cycle counters
    // --------------------------------------------------------------
    logic [GIO_CW-1:0] clock_tick_counter;
    logic [GIO_CW-1:0] slave_count;
    logic [GIO_CW-1:0] next_clock_tick_counter;
    logic [GIO_CW-1:0] next_slave_count;

    always_comb begin
        next_clock_tick_counter = clock_tick_counter;
        if (COUNT_STALL || !STALL) begin
            next_clock_tick_counter = clock_tick_counter + GIO_CNT_ONE;
        end
        next_slave_count = slave_count;
        if (IJMP_DONE) begin
            next_slave_count = clock_tick_counter;
        end
    end

    // Reset loads the slave with the master's reset value, so both read zero
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            clock_tick_counter <= GIO_CNT_RST;
            slave_count        <= GIO_CNT_RST;
        end else begin
            clock_tick_counter <= next_clock_tick_counter;
            slave_count        <= next_slave_count;
        end
    end

    // --------------------------------------------------------------
    // Decode and one-cycle datapath
    // --------------------------------------------------------------
    logic              slot_alu;
    logic              take;
    logic [GIO_DW-1:0] abs_a;
    logic [GIO_DW-1:0] abs_b;
    gio_wb_t           next_alu_wb;
    logic [GIO_DW-1:0] next_snap_lo;

    assign slot_alu = (ISSUE.slot >= GIO_SLOT_MIN) && (ISSUE.slot <= GIO_SLOT_MAX);
    assign take     = ISSUE.valid && ISSUE.guard;

    always_comb begin
        // Shared two-operand absolute form; the pseudo op feeds zero as first source
        abs_a       = GIO_ZERO32;
        abs_b       = ISSUE.src2;
        next_alu_wb = '0;
        next_alu_wb.dest = ISSUE.dest;
        next_snap_lo = slave_count[GIO_DW-1:0];
        case (ISSUE.opcode)
            GIO_OP_HICYC: begin
                next_alu_wb.we   = take && (ISSUE.slot == GIO_SLOT_FCOMP);
                next_alu_wb.data = slave_count[GIO_CW-1:GIO_DW];
            end
            GIO_OP_ABS: begin
                next_alu_wb.we = take && slot_alu;
                // Most negative input wraps to itself, read as unsigned magnitude
                next_alu_wb.data = abs_b[GIO_DW-1] ? (abs_a - abs_b) : abs_b;
            end
            GIO_OP_ADD: begin
                next_alu_wb.we   = take && slot_alu;
                next_alu_wb.data = ISSUE.src1 + ISSUE.src2;
            end
            GIO_OP_ADDI: begin
                next_alu_wb.we   = take && slot_alu;
                next_alu_wb.data = ISSUE.src1 + {{(GIO_DW-GIO_IMMW){1'b0}}, ISSUE.imm};
            end
            default: begin
                next_alu_wb.we = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            ALU_WB  <= '0;
            SNAP_LO <= '0;
        end else begin
            ALU_WB  <= next_alu_wb;
            SNAP_LO <= next_snap_lo;
        end
    end

    // --------------------------------------------------------------
    // Two-cycle average
    // --------------------------------------------------------------
    logic avg_go;
    logic avg_vld;
    logic [GIO_DESTW-1:0] avg_dest;
    logic [GIO_DW-1:0]    avg_data;

    assign avg_go = take && (ISSUE.opcode == GIO_OP_AVG) &&
                    ((ISSUE.slot == GIO_SLOT_MIN) || (ISSUE.slot == GIO_SLOT_AVG_B));

    gio_avg_stage u_avg (
        .clk      (CLK),
        .rst      (SYS_RST),
        .in_vld   (avg_go),
        .in_dest  (ISSUE.dest),
        .in_a     (ISSUE.src1),
        .in_b     (ISSUE.src2),
        .out_vld  (avg_vld),
        .out_dest (avg_dest),
        .out_data (avg_data)
    );

    // No output register; fed straight from the stage flops, which already register the result
    assign AVG_WB = '{we: avg_vld, dest: avg_dest, data: avg_data};

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    sequence add_issued;
        ISSUE.valid && ISSUE.guard && ISSUE.opcode == GIO_OP_ADD && slot_alu;
    endsequence

    // Average: request at one edge, writeback two edges on
    sequence avg_taken;
        avg_go;
    endsequence

    sequence avg_answer;
        ##2 AVG_WB.we;
    endsequence

    hi_read_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (take && ISSUE.opcode == GIO_OP_HICYC && ISSUE.slot == GIO_SLOT_FCOMP) |=>
        (ALU_WB.we && ALU_WB.data == $past(slave_count[GIO_CW-1:GIO_DW])))
        else $error("High cycle read result wrong");
    slave_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !IJMP_DONE |=> $stable(slave_count))
        else $error("Slave counter changed without jump");
    slave_copy_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        IJMP_DONE |=> slave_count == $past(clock_tick_counter))
        else $error("Slave copy mismatch");
    stall_count_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (STALL && !COUNT_STALL) |=> clock_tick_counter == $past(clock_tick_counter))
        else $error("Counter advanced on stall");
    // Sampled reset skips the release edge, where the counter is still held
    run_count_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!SYS_RST && (COUNT_STALL || !STALL)) |=> clock_tick_counter == $past(clock_tick_counter) + GIO_CNT_ONE)
        else $error("Counter failed to advance");
    guard_off_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ISSUE.valid && !ISSUE.guard) |=> !ALU_WB.we ##1 !AVG_WB.we)
        else $error("Write with false guard");
    add_sum_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        add_issued |=> ALU_WB.data == $past(ISSUE.src1) + $past(ISSUE.src2))
        else $error("Add result wrong");
    abs_val_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (take && slot_alu && ISSUE.opcode == GIO_OP_ABS) |=>
        (ALU_WB.data == ($past(ISSUE.src2[GIO_DW-1]) ? -$past(ISSUE.src2) : $past(ISSUE.src2))))
        else $error("Absolute value wrong");
    addi_sum_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (take && slot_alu && ISSUE.opcode == GIO_OP_ADDI) |=>
        ALU_WB.data == $past(ISSUE.src1) + {25'h0, $past(ISSUE.imm)})
        else $error("Add-immediate wrong");
    avg_time_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        avg_go |=> ##1 (AVG_WB.we && AVG_WB.data ==
        32'((({{32{$past(ISSUE.src1[31],2)}}, $past(ISSUE.src1,2)} +
              {{32{$past(ISSUE.src2[31],2)}}, $past(ISSUE.src2,2)} + 64'h1) >>> 1))))
        else $error("Average result or timing wrong");

    // --------------------------------------------------------------
    // Origin and answer checks: every write traces back to a guarded request, and every average request is answered
    // --------------------------------------------------------------
    avg_answer_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        avg_taken |-> avg_answer)
        else $error("Average writeback missing");
    avg_dest_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        avg_taken |-> ##2 (AVG_WB.dest == $past(ISSUE.dest, 2)))
        else $error("Average destination wrong");
    avg_origin_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        AVG_WB.we |-> $past(avg_go, 2))
        else $error("Average write without request");
    alu_origin_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        ALU_WB.we |-> $past(take))
        else $error("Result write without guarded request");
    alu_dest_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        take |=> ALU_WB.dest == $past(ISSUE.dest))
        else $error("Result destination wrong");
    snap_lo_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        1'b1 |=> SNAP_LO == $past(slave_count[GIO_DW-1:0]))
        else $error("Low word not from slave copy");

    // Refused slots must leave the destination alone
    hi_slot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ISSUE.valid && ISSUE.opcode == GIO_OP_HICYC && ISSUE.slot != GIO_SLOT_FCOMP) |=> !ALU_WB.we)
        else $error("High cycle read outside its slot");
    abs_slot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ISSUE.valid && ISSUE.opcode == GIO_OP_ABS && !slot_alu) |=> !ALU_WB.we)
        else $error("Absolute value outside its slots");
    avg_slot_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        (ISSUE.valid && ISSUE.opcode == GIO_OP_AVG &&
         ISSUE.slot != GIO_SLOT_MIN && ISSUE.slot != GIO_SLOT_AVG_B) |=> ##1 !AVG_WB.we)
        else $error("Average outside its slots");
endmodule

/* File: rtl/gio_pkg.sv */
// Package: opcodes, widths, issue slots, constants and carrier types for the guarded integer unit
package gio_pkg;
    localparam int unsigned GIO_DW       = 32;
    localparam int unsigned GIO_CW       = 64;
    localparam int unsigned GIO_OPW      = 8;
    localparam int unsigned GIO_IMMW     = 7;
    localparam int unsigned GIO_DESTW    = 7;
    // --------------------------------------------------------------
    // Operation codes
    // --------------------------------------------------------------
    localparam logic [GIO_OPW-1:0] GIO_OP_HICYC = 8'h9b;  // 155
    localparam logic [GIO_OPW-1:0] GIO_OP_ABS   = 8'h2c;  // 44
    localparam logic [GIO_OPW-1:0] GIO_OP_ADD   = 8'h0c;  // 12
    localparam logic [GIO_OPW-1:0] GIO_OP_ADDI  = 8'h05;  // 5
    localparam logic [GIO_OPW-1:0] GIO_OP_AVG   = 8'h19;  // 25
    // --------------------------------------------------------------
    // Issue slots and constants
    // --------------------------------------------------------------
    localparam logic [2:0] GIO_SLOT_FCOMP = 3'h3;
    localparam logic [2:0] GIO_SLOT_MIN   = 3'h1;
    localparam logic [2:0] GIO_SLOT_MAX   = 3'h5;
    localparam logic [2:0] GIO_SLOT_AVG_B = 3'h3;
    localparam logic [GIO_CW-1:0] GIO_CNT_RST  = 64'h0;
    localparam logic [GIO_CW-1:0] GIO_CNT_ONE  = 64'h1;
    localparam logic [GIO_DW-1:0] GIO_ZERO32   = 32'h0;

    typedef struct packed {
        logic                 valid;
        logic [GIO_OPW-1:0]   opcode;
        logic [2:0]           slot;
        logic                 guard;      // Lsb of guard register
        logic [GIO_IMMW-1:0]  imm;
        logic [GIO_DESTW-1:0] dest;
        logic [GIO_DW-1:0]    src1;
        logic [GIO_DW-1:0]    src2;
    } gio_issue_t;

    typedef struct packed {
        logic                 we;
        logic [GIO_DESTW-1:0] dest;
        logic [GIO_DW-1:0]    data;
    } gio_wb_t;
endpackage

/* File: rtl/gio_avg_stage.sv */
// Two-cycle rounded signed average pipeline
`timescale 1ns/1ps
module gio_avg_stage
    import gio_pkg::*;
(
    input  wire logic                 clk,       // Core clock
    input  wire logic                 rst,       // Async reset, high
    input  wire logic                 in_vld,    // Guarded request
    input  wire logic [GIO_DESTW-1:0] in_dest,   // Destination
    input  wire logic [GIO_DW-1:0]    in_a,      // First source
    input  wire logic [GIO_DW-1:0]    in_b,      // Second source
    output logic                      out_vld,   // Result valid
    output logic [GIO_DESTW-1:0]      out_dest,  // Result destination
    output logic [GIO_DW-1:0]         out_data   // Result
);
    logic                 s1_vld;
    logic [GIO_DESTW-1:0] s1_dest;
    logic [GIO_DW:0]      s1_sum;
    logic                 next_s1_vld;
    logic [GIO_DESTW-1:0] next_s1_dest;
    logic [GIO_DW:0]      next_s1_sum;

    // 33-bit sum suffices: the 64-bit sign extension only replicates bit 32
    always_comb begin
        next_s1_vld  = in_vld;
        next_s1_dest = in_dest;
        next_s1_sum  = {in_a[GIO_DW-1], in_a} + {in_b[GIO_DW-1], in_b} + (GIO_DW+1)'(1);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_vld   <= 1'b0;
            s1_dest  <= '0;
            s1_sum   <= '0;
            out_vld  <= 1'b0;
            out_dest <= '0;
            out_data <= '0;
        end else begin
            s1_vld   <= next_s1_vld;
            s1_dest  <= next_s1_dest;
            s1_sum   <= next_s1_sum;
            out_vld  <= s1_vld;
            out_dest <= s1_dest;
            out_data <= s1_sum[GIO_DW:1];
        end
    end
endmodule

/* File: tb/gio_regfile_model.sv */
// Register file model that takes the unit's writebacks
`timescale 1ns/1ps
module gio_regfile_model
    import gio_pkg::*;
(
    input  wire logic                 clk,      // Core clock
    input  wire logic                 rst,      // Async reset, high
    input  wire gio_pkg::gio_wb_t     alu_wb,   // One-cycle writeback
    input  wire gio_pkg::gio_wb_t     avg_wb,   // Two-cycle writeback
    input  wire logic [GIO_DESTW-1:0] rd_addr,  // Read address
    output logic [GIO_DW-1:0]         rd_data   // Read data
);
    logic [GIO_DW-1:0] regs [2**GIO_DESTW];
    // Both ports may write in one cycle; the average wins on a shared destination
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 2**GIO_DESTW; i++) begin
                regs[i] <= GIO_ZERO32;
            end
        end else begin
            if (alu_wb.we) begin
                regs[alu_wb.dest] <= alu_wb.data;
            end
            if (avg_wb.we) begin
                regs[avg_wb.dest] <= avg_wb.data;
            end
        end
    end
    assign rd_data = regs[rd_addr];
endmodule

/* File: tb/gio_unit_bench.sv */
// Self-checking bench for the guarded integer unit
`timescale 1ns/1ps
module gio_unit_bench;
    import gio_pkg::*;
    typedef struct packed {
        logic [GIO_OPW-1:0]  op;
        logic [2:0]          slot;
        logic                g;
        logic [GIO_IMMW-1:0] imm;
        logic [GIO_DW-1:0]   s1;
        logic [GIO_DW-1:0]   s2;
        logic                we;
        logic [GIO_DW-1:0]   res;
    } gio_row_t;
    logic clk, sys_rst, stall, count_stall, ijmp;
    gio_issue_t issue;
    gio_wb_t alu_wb, avg_wb;
    logic [GIO_DW-1:0] snap_lo, rd_data;
    logic [GIO_DESTW-1:0] rd_addr;
    int err_count, num_checks;
    gio_row_t rows [21] = '{
        '{GIO_OP_ABS, 3'h1, 1'b1, 7'h0, 32'h0, 32'hfffffff4, 1'b1, 32'hc},
        '{GIO_OP_ABS, 3'h5, 1'b1, 7'h0, 32'h0, 32'hffffffff, 1'b1, 32'h1},
        '{GIO_OP_ABS, 3'h2, 1'b1, 7'h0, 32'h0, 32'h80000001, 1'b1, 32'h7fffffff},
        '{GIO_OP_ABS, 3'h4, 1'b1, 7'h0, 32'h0, 32'h80000000, 1'b1, 32'h80000000},
        '{GIO_OP_ADD, 3'h2, 1'b1, 7'h0, 32'h100, 32'hf11, 1'b1, 32'h1011},
        '{GIO_OP_ADD, 3'h3, 1'b1, 7'h0, 32'hffffff00, 32'hffffff9c, 1'b1, 32'hfffffe9c},
        '{GIO_OP_ADD, 3'h5, 1'b1, 7'h0, 32'hffffffff, 32'h1, 1'b1, 32'h0},
        '{GIO_OP_ADDI, 3'h4, 1'b1, 7'h7f, 32'hf11, 32'h0, 1'b1, 32'hf90},
        '{GIO_OP_ADDI, 3'h1, 1'b1, 7'h11, 32'hfffffff0, 32'h0, 1'b1, 32'h1},
        '{GIO_OP_ADDI, 3'h5, 1'b1, 7'h0, 32'h1234, 32'hffff, 1'b1, 32'h1234},
        '{GIO_OP_AVG, 3'h1, 1'b1, 7'h0, 32'h10, 32'h20, 1'b1, 32'h18},
        '{GIO_OP_AVG, 3'h3, 1'b1, 7'h0, 32'hfffffff7, 32'h2, 1'b1, 32'hfffffffd},
        '{GIO_OP_AVG, 3'h1, 1'b1, 7'h0, 32'h7fffffff, 32'h7fffffff, 1'b1, 32'h7fffffff},
        '{GIO_OP_AVG, 3'h3, 1'b1, 7'h0, 32'h80000000, 32'h80000000, 1'b1, 32'h80000000},
        '{GIO_OP_HICYC, 3'h3, 1'b1, 7'h0, 32'h5, 32'h6, 1'b1, 32'h0},
        '{GIO_OP_ADD, 3'h1, 1'b0, 7'h0, 32'h1, 32'h1, 1'b0, 32'h0},
        '{GIO_OP_ABS, 3'h0, 1'b1, 7'h0, 32'h0, 32'h5, 1'b0, 32'h0},
        '{GIO_OP_ABS, 3'h6, 1'b1, 7'h0, 32'h0, 32'h5, 1'b0, 32'h0},
        '{GIO_OP_AVG, 3'h2, 1'b1, 7'h0, 32'h1, 32'h1, 1'b0, 32'h0},
        '{GIO_OP_HICYC, 3'h2, 1'b1, 7'h0, 32'h0, 32'h0, 1'b0, 32'h0},
        '{8'hff, 3'h1, 1'b1, 7'h0, 32'h1, 32'h1, 1'b0, 32'h0}};
    gio_unit uut (.CLK(clk), .SYS_RST(sys_rst), .ISSUE(issue), .STALL(stall), .COUNT_STALL(count_stall),
        .IJMP_DONE(ijmp), .ALU_WB(alu_wb), .AVG_WB(avg_wb), .SNAP_LO(snap_lo));
    gio_regfile_model rf (.clk(clk), .rst(sys_rst), .alu_wb(alu_wb), .avg_wb(avg_wb), .rd_addr(rd_addr),
        .rd_data(rd_data));
    // --------------------------------------------------------------
    // Checking and stimulus tasks
    // --------------------------------------------------------------
    task automatic chk_wb(input gio_wb_t got, input logic we, input logic [GIO_DESTW-1:0] d, input logic [31:0] x);
        num_checks++;
        if (got.we !== we || (we && (got.dest !== d || got.data !== x))) begin
            err_count++;
            $display("MISMATCH t=%0t writeback we=%b data=%h expected %b %h", $time, got.we, got.data, we, x);
        end
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] x);
        num_checks++;
        if (got !== x) begin
            err_count++;
            $display("MISMATCH t=%0t word %h expected %h", $time, got, x);
        end
    endtask
    // Latencies are fixed, so each wait is a known edge count
    task automatic run_row(input gio_row_t r, input logic [GIO_DESTW-1:0] d);
        gio_wb_t a;
        logic av;
        av = (r.op === GIO_OP_AVG);
        @(posedge clk);
        issue <= '{1'b1, r.op, r.slot, r.g, r.imm, d, r.s1, r.s2};
        @(posedge clk);
        issue.valid <= 1'b0;
        #1;
        a = alu_wb;
        @(posedge clk);
        #1;
        chk_wb(a, r.we & !av, d, r.res);
        chk_wb(avg_wb, r.we & av, d, r.res);
    endtask
    // Two jumps nine edges apart; the low word moves only at the jumps
    task automatic cnt_span(input logic st, input logic cs);
        logic [31:0] v0;
        @(posedge clk);
        stall <= st;
        count_stall <= cs;
        ijmp <= 1'b1;
        @(posedge clk);
        ijmp <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        v0 = snap_lo;
        repeat (4) @(posedge clk);
        #1;
        chk32(snap_lo, v0);
        @(posedge clk);
        ijmp <= 1'b1;
        @(posedge clk);
        ijmp <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk32(snap_lo - v0, (!st || cs) ? 32'h9 : 32'h0);
    endtask
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("MISMATCH t=%0t run did not finish", $time);
        final_report();
    end
    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        {sys_rst, stall, count_stall, ijmp, issue, rd_addr} = '0;
        sys_rst = 1'b1;
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk32(snap_lo, 32'h0);
        for (int i = 0; i < 21; i++) begin
            run_row(rows[i], 7'(i));
        end
        $display("table test done");
        @(posedge clk);
        issue <= '{1'b1, GIO_OP_AVG, 3'h1, 1'b1, 7'h0, 7'd40, 32'h10, 32'h20};
        rd_addr <= 7'd41;
        @(posedge clk);
        issue <= '{1'b1, GIO_OP_ADD, 3'h2, 1'b1, 7'h0, 7'd41, 32'h1, 32'h2};
        @(posedge clk);
        issue.valid <= 1'b0;
        #1;
        chk_wb(alu_wb, 1'b1, 7'd41, 32'h3);
        chk_wb(avg_wb, 1'b1, 7'd40, 32'h18);
        run_row('{GIO_OP_ADD, 3'h2, 1'b0, 7'h0, 32'h5, 32'h5, 1'b0, 32'h0}, 7'd41);
        chk32(rd_data, 32'h3);
        $display("overlap and guard test done");
        for (int k = 0; k < 4; k++) begin
            cnt_span(k[0], k[1]);
        end
        // Slave low word is non-zero now, so a wrong half would show here
        run_row('{GIO_OP_HICYC, 3'h3, 1'b1, 7'h0, 32'h0, 32'h0, 1'b1, 32'h0}, 7'd50);
        $display("counter test done");
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
        #1;
        chk32(snap_lo, 32'h0);
        $display("reset test done");
        final_report();
    end
endmodule
